// ==== inc/aoc_defs.vh ====
`ifndef AOC_DEFS_VH
`define AOC_DEFS_VH
// output format codes
`define AOC_FMT_FULL 2'h0
`define AOC_FMT_DDR_SE 2'h1
`define AOC_FMT_DDR_DIFF 2'h2
// drive current codes, 1.75 2.1 2.5 3.0 3.5 4.0 4.5 mA
`define AOC_CUR_1P75 3'h0
`define AOC_CUR_2P1 3'h1
`define AOC_CUR_2P5 3'h2
`define AOC_CUR_3P0 3'h3
`define AOC_CUR_3P5 3'h4
`define AOC_CUR_4P0 3'h5
`define AOC_CUR_4P5 3'h6
`define AOC_CUR_DEFAULT 3'h4
// output configuration register fields
`define AOC_OCFG_FMT_LSB 0
`define AOC_OCFG_CUR_LSB 2
`define AOC_OCFG_RESET 8'h10
// timing configuration register: stabilizer enable bit
`define AOC_TCFG_DCS_BIT 0
`define AOC_TCFG_RESET 8'h00
// stabilizer relock, in encode cycles
`define AOC_DCS_LOCK_CYCLES 100
// grounded complement: low for longer than any encode half period, in mclk
`define AOC_SE_DETECT_CYCLES 8'h20
`define AOC_SAMPLE_BITS 14
`define AOC_PAIR_LINES 7
`endif

// ==== verilog/aoc_dcs_lock.v ====
`timescale 1ns/1ps
`default_nettype none
`include "aoc_defs.vh"
// counts encode edges after enable or a period change before lock
module aoc_dcs_lock #(
   parameter LOCK_CYCLES = `AOC_DCS_LOCK_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire enable,
   input wire enc_edge,
   output reg locked
);
   reg [7:0] count;
   reg [7:0] period;
   reg [7:0] last_period;
   wire period_jump;

   // a period that moves by more than one mclk means the encode rate changed
   assign period_jump = enc_edge && (count != 8'h00) &&
      ((period > last_period + 8'h01) || (period + 8'h01 < last_period));

   always @(posedge mclk) begin
      if (rst) begin
         count <= 8'h00;
         period <= 8'h00;
         last_period <= 8'h00;
         locked <= 1'b0;
      end else begin
         if (enc_edge) begin
            period <= 8'h00;
            last_period <= period;
         end else if (period != 8'hff) begin
            period <= period + 8'h01;
         end
         if (!enable || period_jump || period == 8'hff) begin
            count <= 8'h00;
            locked <= 1'b0;
         end else if (enc_edge && !locked) begin
            if (count == LOCK_CYCLES[7:0] - 8'h01) begin
               locked <= 1'b1;
            end
            count <= count + 8'h01;
         end
      end
   end
endmodule // aoc_dcs_lock
`default_nettype wire

// ==== verilog/aoc_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "aoc_defs.vh"
module aoc_top #(
   parameter NBITS = `AOC_SAMPLE_BITS,
   parameter NPAIRS = `AOC_PAIR_LINES,
   parameter LOCK_CYCLES = `AOC_DCS_LOCK_CYCLES
) (
   input wire mclk,
   input wire rst,
   input wire encode_in_pos,
   input wire encode_in_neg,
   input wire program_mode_strap,
   input wire par_sclk_pin,
   input wire par_cs_pin,
   input wire [7:0] output_cfg_reg,
   input wire [7:0] timing_cfg_reg,
   input wire [NBITS-1:0] conv_sample,
   input wire conv_overflow,
   output reg [NBITS-1:0] sample_bits,
   output reg [NPAIRS-1:0] ddr_bit_pair_lines,
   output reg [NPAIRS-1:0] ddr_bit_pair_lines_n,
   output reg range_overflow_flag,
   output reg range_overflow_flag_n,
   output reg fwd_out_clock_pos,
   output reg fwd_out_clock_neg,
   output reg [1:0] out_format,
   output reg [2:0] drive_current,
   output reg dcs_enabled,
   output wire dcs_locked,
   output reg single_ended_encode,
   output reg sample_strobe
);
   // the encode, strap, sclk and cs pins first pass two flops; rst and the config and converter inputs do not
   reg [1:0] s_pos;
   reg [1:0] s_neg;
   reg [1:0] s_par;
   reg [1:0] s_sck;
   reg [1:0] s_cs;
   reg enc_d;
   reg enc_level;
   reg [7:0] neg_low_count;
   reg [NBITS-1:0] word;
   reg word_of;
   wire enc_rise;
   wire enc_fall;
   wire [1:0] cfg_fmt;
   wire [2:0] cfg_cur;
   reg [1:0] next_format;
   reg [2:0] next_current;
   reg next_dcs;

   always @(posedge mclk) begin
      if (rst) begin
         s_pos <= 2'h0;
         s_neg <= 2'h3;
         s_par <= 2'h0;
         s_sck <= 2'h0;
         s_cs <= 2'h0;
      end else begin
         s_pos <= {s_pos[0], encode_in_pos};
         s_neg <= {s_neg[0], encode_in_neg};
         s_par <= {s_par[0], program_mode_strap};
         s_sck <= {s_sck[0], par_sclk_pin};
         s_cs <= {s_cs[0], par_cs_pin};
      end
   end

   // negative input low means a single-ended square wave on the positive one
   always @(posedge mclk) begin
      if (rst) begin
         single_ended_encode <= 1'b0;
         neg_low_count <= 8'h00;
         enc_level <= 1'b0;
         enc_d <= 1'b0;
      end else begin
         // differential drive dips low every half period; only a sustained
         // low counts, so differential encode needs half periods under the limit
         if (s_neg[1]) begin
            neg_low_count <= 8'h00;
            single_ended_encode <= 1'b0;
         end else if (neg_low_count == `AOC_SE_DETECT_CYCLES) begin
            single_ended_encode <= 1'b1;
         end else begin
            neg_low_count <= neg_low_count + 8'h01;
         end
         enc_level <= s_neg[1] ? (s_pos[1] & !s_neg[1]) | (s_pos[1] ^ s_neg[1]) & s_pos[1]
            : s_pos[1];
         enc_d <= enc_level;
      end
   end

   assign enc_rise = enc_level && !enc_d;
   assign enc_fall = !enc_level && enc_d;

   assign cfg_fmt = output_cfg_reg[`AOC_OCFG_FMT_LSB +: 2];
   assign cfg_cur = output_cfg_reg[`AOC_OCFG_CUR_LSB +: 3];

   always @* begin
      if (s_par[1]) begin
         // parallel pins cannot reach ddr single-ended
         next_format = s_sck[1] ? `AOC_FMT_DDR_DIFF : `AOC_FMT_FULL;
         next_current = `AOC_CUR_DEFAULT;
         next_dcs = s_cs[1];
      end else begin
         // unused code 3 falls back to full rate
         next_format = (cfg_fmt == 2'h3) ? `AOC_FMT_FULL : cfg_fmt;
         // code 7 is not a level, keep the default
         next_current = (cfg_cur == 3'h7) ? `AOC_CUR_DEFAULT : cfg_cur;
         next_dcs = timing_cfg_reg[`AOC_TCFG_DCS_BIT];
      end
   end

   // settings change only at sample boundaries so a word is never split
   always @(posedge mclk) begin
      if (rst) begin
         out_format <= `AOC_FMT_FULL;
         drive_current <= `AOC_CUR_DEFAULT;
         dcs_enabled <= 1'b0;
      end else if (enc_rise) begin
         out_format <= next_format;
         drive_current <= next_current;
         dcs_enabled <= next_dcs;
      end
   end

   aoc_dcs_lock #(
      .LOCK_CYCLES(LOCK_CYCLES)
   ) u_lock (
      .mclk(mclk),
      .rst(rst),
      .enable(dcs_enabled),
      .enc_edge(enc_rise),
      .locked(dcs_locked)
   );

   // capture sample and flag together on the encode rise
   always @(posedge mclk) begin
      if (rst) begin
         word <= {NBITS{1'b0}};
         word_of <= 1'b0;
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= enc_rise;
         if (enc_rise) begin
            word <= conv_sample;
            word_of <= conv_overflow;
         end
      end
   end

   // forwarded clock: low for the first half, high for the second.
   // the internal phase follows the encode edges; the stabilizer does not change the
   // halves, a hardware duty fix cannot be shown at mclk rate
   always @(posedge mclk) begin
      if (rst) begin
         sample_bits <= {NBITS{1'b0}};
         ddr_bit_pair_lines <= {NPAIRS{1'b0}};
         ddr_bit_pair_lines_n <= {NPAIRS{1'b1}};
         range_overflow_flag <= 1'b0;
         range_overflow_flag_n <= 1'b1;
         fwd_out_clock_pos <= 1'b0;
         fwd_out_clock_neg <= 1'b1;
      end else if (sample_strobe) begin
         fwd_out_clock_pos <= 1'b0;
         fwd_out_clock_neg <= 1'b1;
         range_overflow_flag <= word_of;
         range_overflow_flag_n <= (out_format == `AOC_FMT_DDR_DIFF) ? !word_of : 1'b1;
         if (out_format == `AOC_FMT_FULL) begin
            sample_bits <= word;
            ddr_bit_pair_lines <= {NPAIRS{1'b0}};
            ddr_bit_pair_lines_n <= {NPAIRS{1'b1}};
         end else begin
            sample_bits <= {NBITS{1'b0}};
            ddr_bit_pair_lines <= even_bits(word);
            ddr_bit_pair_lines_n <= (out_format == `AOC_FMT_DDR_DIFF) ?
               ~even_bits(word) : {NPAIRS{1'b1}};
         end
      end else if (enc_fall) begin
         fwd_out_clock_pos <= 1'b1;
         fwd_out_clock_neg <= 1'b0;
         if (out_format != `AOC_FMT_FULL) begin
            ddr_bit_pair_lines <= odd_bits(word);
            ddr_bit_pair_lines_n <= (out_format == `AOC_FMT_DDR_DIFF) ?
               ~odd_bits(word) : {NPAIRS{1'b1}};
         end
      end
   end

   function [NPAIRS-1:0] even_bits;
      input [NBITS-1:0] w;
      integer i;
      begin
         for (i = 0; i < NPAIRS; i = i + 1) begin
            even_bits[i] = w[2*i];
         end
      end
   endfunction

   function [NPAIRS-1:0] odd_bits;
      input [NBITS-1:0] w;
      integer i;
      begin
         for (i = 0; i < NPAIRS; i = i + 1) begin
            odd_bits[i] = w[2*i+1];
         end
      end
   endfunction
endmodule // aoc_top
`default_nettype wire

// ==== dv/aoc_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module aoc_sva (
   input wire logic mclk,
   input wire logic rst,
   input wire logic program_mode_strap,
   input wire logic [13:0] conv_sample,
   input wire logic conv_overflow,
   input wire logic [13:0] sample_bits,
   input wire logic [6:0] ddr_bit_pair_lines,
   input wire logic [6:0] ddr_bit_pair_lines_n,
   input wire logic range_overflow_flag,
   input wire logic range_overflow_flag_n,
   input wire logic fwd_out_clock_pos,
   input wire logic fwd_out_clock_neg,
   input wire logic [1:0] out_format,
   input wire logic sample_strobe
);
   logic [14:0] cs_d, cap;
   logic [6:0] ev, od;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // word as taken at the encode rise, one edge before the strobe
   always @(posedge mclk) begin
      cs_d <= {conv_overflow, conv_sample};
      if (sample_strobe) cap <= cs_d;
   end
   for (genvar i = 0; i < 7; i++) begin : g_split
      assign ev[i] = cap[2*i];
      assign od[i] = cap[2*i+1];
   end
   sequence s_full; sample_strobe ##1 out_format == 2'h0; endsequence
   sequence s_ddr; sample_strobe ##1 out_format != 2'h0; endsequence
   sequence s_diff; sample_strobe ##1 out_format == 2'h2; endsequence
   property p_full; s_full |-> sample_bits == cap[13:0] && !fwd_out_clock_pos; endproperty
   property p_ovf; sample_strobe |=> range_overflow_flag == cap[14]; endproperty
   property p_even; s_ddr |-> ddr_bit_pair_lines == ev && !fwd_out_clock_pos && sample_bits == 14'h0;
   endproperty
   property p_odd; $rose(fwd_out_clock_pos) && out_format != 2'h0 |-> ddr_bit_pair_lines == od;
   endproperty
   property p_pair; fwd_out_clock_neg == !fwd_out_clock_pos; endproperty
   property p_diff; s_diff |-> ddr_bit_pair_lines_n == ~ddr_bit_pair_lines
      && range_overflow_flag_n == !range_overflow_flag; endproperty
   property p_strobe; sample_strobe |=> !sample_strobe; endproperty
   property p_par; program_mode_strap |-> out_format != 2'h1; endproperty
   a_full: assert property (p_full) else $error("full word wrong");
   a_ovf: assert property (p_ovf) else $error("overflow wrong");
   a_even: assert property (p_even) else $error("even bits wrong");
   a_odd: assert property (p_odd) else $error("odd bits wrong");
   a_pair: assert property (p_pair) else $error("clock pair wrong");
   a_diff: assert property (p_diff) else $error("pairs wrong");
   a_strobe: assert property (p_strobe) else $error("strobe long");
   a_par: assert property (p_par) else $error("ddr se in parallel");
endmodule // aoc_sva
bind aoc_top aoc_sva sva_u (.mclk, .rst, .program_mode_strap, .conv_sample, .conv_overflow,
   .sample_bits, .ddr_bit_pair_lines, .ddr_bit_pair_lines_n, .range_overflow_flag,
   .range_overflow_flag_n, .fwd_out_clock_pos, .fwd_out_clock_neg, .out_format,
   .sample_strobe);
`default_nettype wire

// ==== dv/aoc_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aoc_rx_model (
   input wire logic mclk,
   input wire logic ddr,
   input wire logic [13:0] sample_bits,
   input wire logic [6:0] lines,
   input wire logic ovf,
   input wire logic clk_pos,
   output logic [14:0] word,
   output logic got
);
   logic clk_d;
   logic [6:0] even;
   always @(posedge mclk) begin
      clk_d <= clk_pos;
      got <= clk_pos && !clk_d;
      if (!clk_pos) even <= lines;
      // capture on the forwarded clock rise
      if (clk_pos && !clk_d) begin
         for (int i = 0; i < 7; i++) begin
            word[2*i] <= ddr ? even[i] : sample_bits[2*i];
            word[2*i+1] <= ddr ? lines[i] : sample_bits[2*i+1];
         end
         word[14] <= ovf;
      end
   end
endmodule // aoc_rx_model
`default_nettype wire

// ==== dv/aoc_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aoc_defs.vh"
module aoc_top_tb;
   logic mclk = 0, rst = 1, enc = 0, se = 0, strap = 1, sclk = 0, cs = 0, of = 0;
   logic [7:0] ocfg = 0, tcfg = 0;
   logic [13:0] conv = 0, sb;
   logic [6:0] ln;
   logic ovf, ck_p, dcs, lk, sen, got;
   logic [1:0] fmt;
   logic [2:0] cur;
   logic [14:0] word;
   int n_fail = 0, compares = 0, cyc = 0;
   initial forever #50 mclk = ~mclk;
   // phase offset keeps encode edges off the mclk edges
   // one fixed rate inside the stabilizer's range, never stepped
   initial begin #37; forever #400 enc = ~enc; end
   aoc_top #(.LOCK_CYCLES(4)) dut_u (.mclk, .rst, .encode_in_pos(enc),
      .encode_in_neg(se ? 1'b0 : ~enc), .program_mode_strap(strap), .par_sclk_pin(sclk),
      .par_cs_pin(cs), .output_cfg_reg(ocfg), .timing_cfg_reg(tcfg), .conv_sample(conv),
      .conv_overflow(of), .sample_bits(sb), .ddr_bit_pair_lines(ln), .ddr_bit_pair_lines_n(),
      .range_overflow_flag(ovf), .range_overflow_flag_n(), .fwd_out_clock_pos(ck_p),
      .fwd_out_clock_neg(), .out_format(fmt), .drive_current(cur), .dcs_enabled(dcs),
      .dcs_locked(lk), .single_ended_encode(sen), .sample_strobe());
   aoc_rx_model rx_u (.mclk, .ddr(fmt != 2'h0), .sample_bits(sb), .lines(ln), .ovf,
      .clk_pos(ck_p), .word, .got);
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      if (n_fail == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_enc(int n);
      repeat (n) @(negedge enc);
      @(negedge mclk);
   endtask
   task automatic send(logic [13:0] w, logic o);
      wait_enc(1);
      conv = w;
      of = o;
      wait_enc(1);
      repeat (8) if (!got) @(negedge mclk);
      chk("word", word, {o, w});
   endtask
   task t_par;
      send(14'h2aaa, 1);
      chk("fmt", fmt, `AOC_FMT_FULL);
      sclk = 1;
      send(14'h1555, 0);
      send(14'h0f0f, 1);
      chk("fmt", fmt, `AOC_FMT_DDR_DIFF);
      chk("cur", cur, `AOC_CUR_3P5);
      cs = 1;
      wait_enc(2);
      chk("dcs", dcs, 1);
      chk("lock", lk, 0);
      wait_enc(6);
      chk("lock", lk, 1);
      cs = 0;
      wait_enc(2);
      chk("dcs", dcs, 0);
   endtask
   task t_ser;
      strap = 0;
      for (int k = 0; k < 8; k++) begin
         // ddr single-ended only ever runs at this slow bench rate
         ocfg = {3'h0, k[2:0], k[1:0]};
         send(14'h3a5c ^ k[13:0], k[0]);
         send(14'h0c3a + k[13:0], k[1]);
         chk("fmt", fmt, k[1:0] == 2'h3 ? 2'h0 : k[1:0]);
         chk("cur", cur, k == 7 ? `AOC_CUR_DEFAULT : k[2:0]);
      end
      tcfg = 8'h01;
      wait_enc(3);
      chk("dcs", dcs, 1);
   endtask
   task t_se;
      chk("se", sen, 0);
      se = 1;
      wait_enc(6);
      chk("se", sen, 1);
      send(14'h3fff, 1);
      se = 0;
      wait_enc(2);
      chk("se", sen, 0);
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run;
      end
   end
   initial begin
      repeat (2) @(negedge mclk);
      rst = 0;
      @(negedge mclk);
      chk("cur", cur, `AOC_CUR_DEFAULT);
      chk("lock", {dcs, lk}, 0);
      t_par;
      t_ser;
      t_se;
      complete_run;
   end
endmodule // aoc_top_tb
`default_nettype wire
